// [include/ts_pkg.sv]
// Notes on behaviour
// - sample one and sample two phase register bits 2:0 give the 8 ns slot of 40 ns (sample three has no phase register)
// - slot one reads 000, slot two reads 001
// - slot four reads 011, slot five reads 100
// - slot three has its own distinct code
// - nanoseconds bit 30 is 1 for rising edge, 0 for falling
// - nanoseconds bits 29:0 hold captured nanoseconds, bit 31 reads zero
// - seconds register holds full 32-bit captured seconds, read-only
// - sample registers show the unit picked by index pointer bit 8
// - each sample position keeps its own flag, ns, seconds and phase
// - edge count saturates at 15 and then sets the overflow flag
package ts_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h550;
  localparam logic [11:0] S1_PH_OFS = 12'h55c;
  localparam logic [11:0] S2_NS_OFS = 12'h560;
  localparam logic [11:0] S2_SEC_OFS = 12'h564;
  localparam logic [11:0] S2_PH_OFS = 12'h568;
  localparam logic [11:0] S3_NS_OFS = 12'h56c;
  localparam logic [11:0] S3_SEC_OFS = 12'h570;
  localparam logic [11:0] INDEX_OFS = 12'h600;
  // ---------------------------------------------------------------
  // field positions and limits
  // ---------------------------------------------------------------
  localparam int RISE_BIT = 7;
  localparam int FALL_BIT = 6;
  localparam int OVF_BIT = 16;
  localparam int CNT_LSB = 17;
  localparam int POL_BIT = 30;
  localparam int PTR_BIT = 8;
  localparam int UNITS = 2;
  localparam int SAMPLES = 3;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [3:0] CNT_RST = 4'h0;
  // ---------------------------------------------------------------
  // slot codes and bus response codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SLOT0 = 3'h0;
  localparam logic [2:0] SLOT1 = 3'h1;
  localparam logic [2:0] SLOT2 = 3'h2;
  localparam logic [2:0] SLOT3 = 3'h3;
  localparam logic [2:0] SLOT4 = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } tod_type;
  typedef struct packed {
    logic pol;
    logic [31:0] sec;
    logic [29:0] ns;
    logic [2:0] code;
  } sample_type;
endpackage

// [design/ts_sample_readout.sv]
module ts_sample_readout (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // axi4-lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // time base and event inputs
  input wire ts_pkg::tod_type i_tod,
  input wire logic [ts_pkg::UNITS-1:0] i_event,
  input wire logic [ts_pkg::UNITS-1:0][2:0] i_event_slot
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] slot_code(input logic [2:0] idx);
    logic [2:0] c;
    c = ts_pkg::SLOT4;
    unique case (idx)
      3'h0: c = ts_pkg::SLOT0;
      3'h1: c = ts_pkg::SLOT1;
      3'h2: c = ts_pkg::SLOT2;
      3'h3: c = ts_pkg::SLOT3;
      default: c = ts_pkg::SLOT4;
    endcase
    return c;
  endfunction

  function automatic logic [11:0] word(input logic [11:0] a);
    return {a[11:2], 2'h0};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic sel_q;
  logic [ts_pkg::UNITS-1:0] rise_en_q, fall_en_q, prev_q, ovf_q;
  logic [ts_pkg::UNITS-1:0] rise, fall, hit, clr;
  logic [3:0] cnt_q [ts_pkg::UNITS];
  ts_pkg::sample_type smp_q [ts_pkg::UNITS][ts_pkg::SAMPLES];
  logic aw_q, w_q, wr_go;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [11:0] rd_addr_q;

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_q <= '0;
    end else begin
      prev_q <= i_event;
    end
  end

  always_comb begin
    rise = i_event & ~prev_q;
    fall = ~i_event & prev_q;
    hit = (rise & rise_en_q) | (fall & fall_en_q);
  end

  // ---------------------------------------------------------------
  // event count, overflow; a capture in the clearing cycle cancels the count clear (or, at 15, the overflow clear)
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int u = 0; u < ts_pkg::UNITS; u++) begin
        cnt_q[u] <= ts_pkg::CNT_RST;
      end
      ovf_q <= '0;
    end else begin
      for (int u = 0; u < ts_pkg::UNITS; u++) begin
        if (clr[u]) begin
          cnt_q[u] <= ts_pkg::CNT_RST;
          ovf_q[u] <= 1'b0;
        end
        if (hit[u]) begin
          if (cnt_q[u] == ts_pkg::CNT_MAX) begin
            ovf_q[u] <= 1'b1;
          end else begin
            cnt_q[u] <= cnt_q[u] + 4'h1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // sample records, one slot per position
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int u = 0; u < ts_pkg::UNITS; u++) begin
        for (int s = 0; s < ts_pkg::SAMPLES; s++) begin
          smp_q[u][s] <= '0;
        end
      end
    end else begin
      for (int u = 0; u < ts_pkg::UNITS; u++) begin
        for (int s = 0; s < ts_pkg::SAMPLES; s++) begin
          if (hit[u] && cnt_q[u] == 4'(s)) begin
            smp_q[u][s].pol <= rise[u];
            smp_q[u][s].ns <= i_tod.ns;
            smp_q[u][s].sec <= i_tod.sec;
            smp_q[u][s].code <= slot_code(i_event_slot[u]);
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  assign o_awready = !aw_q && !o_bvalid;
  assign o_wready = !w_q && !o_bvalid;
  assign wr_go = aw_q && w_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      o_bvalid <= 1'b0;
      o_bresp <= ts_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= word(i_awaddr);
      end
      if (i_wvalid && o_wready) begin
        w_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        o_bvalid <= 1'b1;
        // sample registers are read-only, so writes there are refused
        o_bresp <= (awaddr_q == ts_pkg::CTRL_OFS ||
                    awaddr_q == ts_pkg::INDEX_OFS) ?
                   ts_pkg::RESP_OKAY : ts_pkg::RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    clr = '0;
    if (wr_go && awaddr_q == ts_pkg::CTRL_OFS && wstrb_q[2]) begin
      clr[sel_q] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // control and index registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_q <= 1'b0;
      rise_en_q <= '0;
      fall_en_q <= '0;
    end else if (wr_go) begin
      if (awaddr_q == ts_pkg::INDEX_OFS && wstrb_q[1]) begin
        sel_q <= wdata_q[ts_pkg::PTR_BIT];
      end
      if (awaddr_q == ts_pkg::CTRL_OFS && wstrb_q[0]) begin
        rise_en_q[sel_q] <= wdata_q[ts_pkg::RISE_BIT];
        fall_en_q[sel_q] <= wdata_q[ts_pkg::FALL_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel, one cycle from address to data
  // ---------------------------------------------------------------
  assign o_arready = !o_rvalid;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= ts_pkg::RESP_OKAY;
      rd_addr_q <= '0;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp <= ts_pkg::RESP_OKAY;
      o_rdata <= '0;
      rd_addr_q <= word(i_araddr);
      unique case (word(i_araddr))
        ts_pkg::CTRL_OFS: begin
          o_rdata[ts_pkg::CNT_LSB +: 4] <= cnt_q[sel_q];
          o_rdata[ts_pkg::OVF_BIT] <= ovf_q[sel_q];
          o_rdata[ts_pkg::RISE_BIT] <= rise_en_q[sel_q];
          o_rdata[ts_pkg::FALL_BIT] <= fall_en_q[sel_q];
        end
        ts_pkg::INDEX_OFS: o_rdata[ts_pkg::PTR_BIT] <= sel_q;
        ts_pkg::S1_PH_OFS: o_rdata[2:0] <= smp_q[sel_q][0].code;
        ts_pkg::S2_NS_OFS: o_rdata[30:0] <= {smp_q[sel_q][1].pol,
                                             smp_q[sel_q][1].ns};
        ts_pkg::S2_SEC_OFS: o_rdata <= smp_q[sel_q][1].sec;
        ts_pkg::S2_PH_OFS: o_rdata[2:0] <= smp_q[sel_q][1].code;
        ts_pkg::S3_NS_OFS: o_rdata[30:0] <= {smp_q[sel_q][2].pol,
                                             smp_q[sel_q][2].ns};
        ts_pkg::S3_SEC_OFS: o_rdata <= smp_q[sel_q][2].sec;
        default: o_rresp <= ts_pkg::RESP_SLVERR;
      endcase
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  slot_two_code_a: assert property (
    hit[1] && cnt_q[1] == 4'h0 && i_event_slot[1] == 3'h1
    |=> smp_q[1][0].code == 3'h1) else $error("slot two code wrong");
  slot_three_code_a: assert property (
    hit[0] && cnt_q[0] == 4'h1 && i_event_slot[0] == 3'h2
    |=> smp_q[0][1].code == 3'h2) else $error("slot three code wrong");
  slot_five_code_a: assert property (
    hit[0] && cnt_q[0] == 4'h0 && i_event_slot[0] == 3'h4
    |=> smp_q[0][0].code == 3'h4) else $error("slot five code wrong");
  phase_upper_zero_a: assert property (
    o_rvalid && rd_addr_q == ts_pkg::S2_PH_OFS |-> o_rdata[31:3] == '0)
    else $error("phase reserved bits set");
  edge_polarity_a: assert property (
    hit[0] && cnt_q[0] == 4'h1 |=> smp_q[0][1].pol == $past(rise[0]))
    else $error("polarity flag wrong");
  time_capture_a: assert property (
    hit[0] && cnt_q[0] == 4'h2 |=> smp_q[0][2].sec == $past(i_tod.sec)
    && smp_q[0][2].ns == $past(i_tod.ns)) else $error("time not captured");
  record_apart_a: assert property (
    hit[0] && cnt_q[0] == 4'h0 |=> $stable(smp_q[0][1]))
    else $error("wrong record written");
  count_saturate_a: assert property (
    hit[1] && cnt_q[1] == 4'hf && !clr[1] |=> cnt_q[1] == 4'hf && ovf_q[1])
    else $error("count did not saturate");
  index_select_a: assert property (
    i_arvalid && o_arready && word(i_araddr) == ts_pkg::S3_SEC_OFS
    |=> o_rvalid && o_rdata == $past(smp_q[sel_q][2].sec))
    else $error("wrong unit read");
  resp_hold_a: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  slot_one_code_a: assert property (
    hit[0] && cnt_q[0] == 4'h2 && i_event_slot[0] == 3'h0
    |=> smp_q[0][2].code == 3'h0) else $error("slot one code wrong");
  slot_four_code_a: assert property (
    hit[1] && cnt_q[1] == 4'h1 && i_event_slot[1] == 3'h3
    |=> smp_q[1][1].code == 3'h3) else $error("slot four code wrong");
  code_range_a: assert property (
    o_rvalid && (rd_addr_q == ts_pkg::S1_PH_OFS ||
    rd_addr_q == ts_pkg::S2_PH_OFS) |-> o_rdata <= 32'h0000_0004)
    else $error("reserved slot code read");
  ns_reserved_a: assert property (
    o_rvalid && rd_addr_q == ts_pkg::S2_NS_OFS |-> !o_rdata[31])
    else $error("nanoseconds reserved bit set");
  unit_select_ns_a: assert property (
    i_arvalid && o_arready && word(i_araddr) == ts_pkg::S2_NS_OFS
    |=> o_rvalid && o_rdata == {1'b0, $past(smp_q[sel_q][1].pol),
    $past(smp_q[sel_q][1].ns)}) else $error("wrong unit nanoseconds");
  phase_select_a: assert property (
    i_arvalid && o_arready && word(i_araddr) == ts_pkg::S2_PH_OFS
    |=> o_rdata[2:0] == $past(smp_q[sel_q][1].code))
    else $error("wrong unit phase");
  refused_write_a: assert property (
    wr_go && awaddr_q == ts_pkg::S2_SEC_OFS
    |=> o_bvalid && o_bresp == ts_pkg::RESP_SLVERR)
    else $error("read-only write accepted");
  overflow_hold_a: assert property (
    ovf_q[1] && !clr[1] |=> ovf_q[1]) else $error("overflow flag lost");
  clear_count_a: assert property (
    clr[1] && !hit[1] |=> cnt_q[1] == ts_pkg::CNT_RST && !ovf_q[1])
    else $error("count not cleared");
  enable_gate_a: assert property (
    fall[1] && !fall_en_q[1] |-> !hit[1]) else $error("disabled edge taken");

  full_count_c: cover property (cnt_q[1] == 4'hf ##1 ovf_q[1]);
  unit_one_read_c: cover property (sel_q && o_rvalid && i_rready);
  falling_capture_c: cover property (fall[0] && hit[0]);
  slot_three_c: cover property (hit[0] && i_event_slot[0] == 3'h2);
  count_clear_c: cover property (clr[1] ##1 cnt_q[1] == 4'h0);
endmodule

// [dv/ts_event_src.sv]
module ts_event_src (
  // clock
  input wire logic i_clk,
  // event lines toward the unit
  output logic [ts_pkg::UNITS-1:0] o_event,
  output logic [ts_pkg::UNITS-1:0][2:0] o_event_slot
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_event = '0;
    o_event_slot = '1;
  end
  // one level change per call, launched just after an edge
  task automatic put(input int u, input logic lvl, input logic [2:0] s);
    o_event[u] <= lvl;
    o_event_slot[u] <= s;
    // slot code only matters at the capture edge; it lingers until next call
    @(posedge i_clk);
  endtask
endmodule

// [dv/event_timestamp_sample_readout_tb_top.sv]
module event_timestamp_sample_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic p;
    logic [11:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } row_type;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, got;
  ts_pkg::tod_type tod = '0;
  logic [ts_pkg::UNITS-1:0] ev;
  logic [ts_pkg::UNITS-1:0][2:0] sl;
  int failures = 0;
  int cmp_count = 0;
  row_type rows[12];
  ts_sample_readout ts_sample_readout_inst (
    .i_clk(clk), .i_nrst(nrst),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_tod(tod), .i_event(ev), .i_event_slot(sl)
  );
  ts_event_src ts_event_src_inst (
    .i_clk(clk), .o_event(ev), .o_event_slot(sl)
  );
  initial begin
    forever #50 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // every bus wait is bounded, a silent slave ends the run
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 100) begin
      failures++;
      $display("[FAIL] bus answer expected 1 seen 0");
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n = 0;
    logic aw = 1'b1;
    logic w = 1'b1;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    while (aw || w) begin
      tick(n);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do tick(n); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    int n = 0;
    arvalid <= 1'b1;
    araddr <= a;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do tick(n); while (rvalid !== 1'b1);
    got = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic sel(input logic p);
    wr(ts_pkg::INDEX_OFS, {23'h0, p, 8'h00}, 4'h2);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    rows[0] = {1'b0, ts_pkg::S1_PH_OFS, 32'h4, ts_pkg::RESP_OKAY};
    rows[1] = {1'b0, ts_pkg::S2_NS_OFS, 32'h2345_6789, ts_pkg::RESP_OKAY};
    rows[2] = {1'b0, ts_pkg::S2_SEC_OFS, 32'h1111_2222, ts_pkg::RESP_OKAY};
    rows[3] = {1'b0, ts_pkg::S2_PH_OFS, 32'h2, ts_pkg::RESP_OKAY};
    rows[4] = {1'b0, ts_pkg::S3_NS_OFS, 32'h7fff_fffe, ts_pkg::RESP_OKAY};
    rows[5] = {1'b0, ts_pkg::S3_SEC_OFS, 32'hffff_0001, ts_pkg::RESP_OKAY};
    rows[6] = {1'b1, ts_pkg::S1_PH_OFS, 32'h1, ts_pkg::RESP_OKAY};
    rows[7] = {1'b1, ts_pkg::S2_NS_OFS, 32'h4000_0123, ts_pkg::RESP_OKAY};
    rows[8] = {1'b1, ts_pkg::S2_SEC_OFS, 32'h8000_0000, ts_pkg::RESP_OKAY};
    rows[9] = {1'b1, ts_pkg::S2_PH_OFS, 32'h3, ts_pkg::RESP_OKAY};
    rows[10] = {1'b1, ts_pkg::S3_SEC_OFS, 32'h0, ts_pkg::RESP_OKAY};
    rows[11] = {1'b0, 12'h554, 32'h0, ts_pkg::RESP_SLVERR};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wr(ts_pkg::CTRL_OFS, 32'h0000_00c0, 4'h1);
    chk("ctrl write resp", 32'h0, {30'h0, rsp});
    sel(1'b1);
    wr(ts_pkg::CTRL_OFS, 32'h0000_0080, 4'h1);
    // back-to-back edges, one per cycle, unit one rising only
    tod <= {32'h0000_00aa, 30'h0000_0bbb};
    ts_event_src_inst.put(0, 1'b1, 3'h4);
    tod <= {32'h1111_2222, 30'h2345_6789};
    ts_event_src_inst.put(0, 1'b0, 3'h2);
    tod <= {32'hffff_0001, 30'h3fff_fffe};
    ts_event_src_inst.put(0, 1'b1, 3'h0);
    ts_event_src_inst.put(1, 1'b1, 3'h1);
    ts_event_src_inst.put(1, 1'b0, 3'h6);
    tod <= {32'h8000_0000, 30'h0000_0123};
    ts_event_src_inst.put(1, 1'b1, 3'h3);
    foreach (rows[i]) begin
      sel(rows[i].p);
      rd(rows[i].a);
      chk($sformatf("row %0d data", i), rows[i].d, got);
      chk($sformatf("row %0d resp", i), {30'h0, rows[i].r}, {30'h0, rsp});
    end
    $display("test table done");
    sel(1'b0);
    wr(ts_pkg::S2_SEC_OFS, 32'hdead_beef, 4'hf);
    chk("ro write resp", 32'h2, {30'h0, rsp});
    rd(ts_pkg::S2_SEC_OFS);
    chk("ro write kept", 32'h1111_2222, got);
    $display("test read-only done");
    sel(1'b1);
    for (int k = 0; k < 14; k++) begin
      ts_event_src_inst.put(1, 1'b0, 3'h0);
      ts_event_src_inst.put(1, 1'b1, 3'h4);
    end
    rd(ts_pkg::CTRL_OFS);
    chk("count saturated", 32'h001f_0080, got);
    wr(ts_pkg::CTRL_OFS, 32'h0000_0080, 4'h5);
    rd(ts_pkg::CTRL_OFS);
    chk("count cleared", 32'h0000_0080, got);
    ts_event_src_inst.put(1, 1'b0, 3'h2);
    ts_event_src_inst.put(1, 1'b1, 3'h0);
    rd(ts_pkg::S1_PH_OFS);
    chk("slot one code", 32'h0, got);
    $display("test overflow done");
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(ts_pkg::S2_SEC_OFS);
    chk("reset seconds two", 32'h0, got);
    rd(ts_pkg::S3_SEC_OFS);
    chk("reset seconds three", 32'h0, got);
    rd(ts_pkg::CTRL_OFS);
    chk("reset ctrl", 32'h0, got);
    $display("test reset done");
    report_and_stop();
  end
endmodule
